// *** design/dicp_pkg.sv ***
// ==========================================================
// shared constants of the sample and control port
package dicp_pkg;
	localparam int unsigned CLK_NS         = 5;
	localparam int unsigned SCLK_PERIOD_NS = 67;
	localparam int unsigned SCLK_HALF      = (SCLK_PERIOD_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
	localparam logic [3:0]  SCLK_LAST      = 4'(SCLK_HALF - 1);
	localparam logic [3:0]  SMP_HALF       = 4'h8;
	localparam logic [3:0]  SMP_LAST       = 4'hF;
	localparam logic [4:0]  SER_BITS       = 5'h10;
	localparam logic [4:0]  SER_INSTR      = 5'h08;
	// device control registers
	localparam int unsigned NREG           = 4;
	localparam logic [6:0]  A_CFG          = 7'h00;
	localparam logic [6:0]  A_MODE         = 7'h01;
	localparam logic [6:0]  A_CLK          = 7'h02;
	localparam int unsigned CFG_DIR_BIT    = 7;
	localparam int unsigned CFG_SRST_BIT   = 5;
	localparam int unsigned MODE_ONE_BIT   = 0;
	localparam int unsigned MODE_PLL_BIT   = 1;
	localparam int unsigned MODE_OUTCK_BIT = 2;
	localparam int unsigned CLK_DIR_BIT    = 3;
	localparam logic [3:0][7:0] REG_RST    = {8'h00, 8'h00, 8'h00, 8'h00};
	// controller registers on the bus
	localparam logic [7:0]  H_CMD          = 8'h00;
	localparam logic [7:0]  H_STAT         = 8'h04;
	localparam logic [7:0]  H_IRQ          = 8'h08;
	localparam logic [7:0]  H_MASK         = 8'h0C;
	localparam logic [7:0]  H_MODE         = 8'h10;
	localparam logic [7:0]  H_SMP          = 8'h14;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	typedef enum {DICP_IDLE, DICP_SHIFT, DICP_GAP} dicp_ser_e;
endpackage

// *** design/dicp_if.sv ***
`timescale 1ns/100ps
// ==========================================================
// pins between sample source / control host and converter
interface dicp_if;
	logic        rate_dev_o;
	logic        rate_dev_oe;
	logic        rate_host_o;
	logic        rate_host_oe;
	logic        rate_clock_or_lock_pin;
	logic [11:0] first_port;
	logic [11:0] second_port_h;
	logic        second_port_h_oe;
	logic        ilv_dev_o;
	logic        ilv_dev_oe;
	logic [11:0] second_port;
	logic        serial_clk;
	logic        serial_select_pin;
	logic        sio_host_o;
	logic        sio_host_oe;
	logic        sio_dev_o;
	logic        sio_dev_oe;
	logic        serial_io;
	logic        serial_out_o;
	logic        serial_out_oe;
	logic        serial_out_pin;
	logic        hw_reset;
	// wire levels worked out from the enables, low when undriven
	assign rate_clock_or_lock_pin = rate_dev_oe ? rate_dev_o : (rate_host_oe & rate_host_o);
	assign second_port = {second_port_h[11], ilv_dev_oe ? ilv_dev_o : (second_port_h_oe & second_port_h[10]),
		second_port_h[9:0]};
	assign serial_io      = sio_dev_oe ? sio_dev_o : (sio_host_oe & sio_host_o);
	assign serial_out_pin = serial_out_oe & serial_out_o;
	modport dev (input first_port, second_port, rate_clock_or_lock_pin, serial_clk, serial_select_pin,
		serial_io, hw_reset, output rate_dev_o, rate_dev_oe, ilv_dev_o, ilv_dev_oe, sio_dev_o, sio_dev_oe,
		serial_out_o, serial_out_oe);
	modport host (input rate_clock_or_lock_pin, second_port, serial_io, serial_out_pin,
		output rate_host_o, rate_host_oe, first_port, second_port_h, second_port_h_oe, serial_clk,
		serial_select_pin, sio_host_o, sio_host_oe, hw_reset);
endinterface

// *** design/dicp_sync.sv ***
`timescale 1ns/100ps
// ==========================================================
// two flop synchroniser for pin inputs
module dicp_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// *** design/dicp_dev.sv ***
`timescale 1ns/100ps
// ==========================================================
// Functional notes
// - shared pin shows lock when PLL on
// - shared pin is rate clock, direction reg 02h bit3
// - one-port: select high to I, low to Q
// - one-port: select pin is second port MSB
// - PLL off, one-port: drive interleave clock out
// - one-port interleaved samples split into I, Q
// - separate out pin drives unless line is output
// - out pin may carry rate clock, two-port
// - reg 00h bit7 sets data line direction
// - serial input bits sampled on rising edge
// - serial output bits launched on falling edge
// - select high resets serial port state except out_r
// - reset pin restores all registers
// - reg 00h bit5 one gives software reset
// - software reset loads the written byte into reg 00h
module dicp_dev (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	dicp_if.dev              lnk,
	input  wire logic        pll_locked,
	output logic      [11:0] i_sample,
	output logic      [11:0] q_sample,
	output logic             sample_valid,
	output logic             one_port,
	output logic             pll_en
);
	// ==========================================================
	// pin synchronisers
	logic [4:0]  pin_s;
	logic [23:0] smp_s;
	logic        sclk_d_r;
	logic        rate_d_r;

	dicp_sync #(.W(5)) u_pin_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({lnk.hw_reset, lnk.rate_clock_or_lock_pin, lnk.serial_io, lnk.serial_select_pin,
			lnk.serial_clk}),
		.q       (pin_s)
	);

	dicp_sync #(.W(24)) u_smp_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({lnk.second_port, lnk.first_port}),
		.q       (smp_s)
	);

	// ==========================================================
	// decoded pin events and register fields
	logic [7:0]  regs_r [dicp_pkg::NREG];
	logic        sclk_s;
	logic        sel_s;
	logic        sdi_s;
	logic        rate_s;
	logic        hw_rst;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        sio_out_cfg;
	logic        rate_is_out;
	logic        out_ck_cfg;
	logic [11:0] p1_s;
	logic [11:0] p2_s;
	logic        chan_sel;

	assign sclk_s      = pin_s[0];
	assign sel_s       = pin_s[1];
	assign sdi_s       = pin_s[2];
	assign rate_s      = pin_s[3];
	assign hw_rst      = pin_s[4];
	assign sclk_rise   = sclk_s & ~sclk_d_r;
	assign sclk_fall   = ~sclk_s & sclk_d_r;
	assign sio_out_cfg = regs_r[0][dicp_pkg::CFG_DIR_BIT];
	assign one_port    = regs_r[1][dicp_pkg::MODE_ONE_BIT];
	assign pll_en      = regs_r[1][dicp_pkg::MODE_PLL_BIT];
	assign out_ck_cfg  = regs_r[1][dicp_pkg::MODE_OUTCK_BIT];
	assign rate_is_out = regs_r[2][dicp_pkg::CLK_DIR_BIT];
	assign p1_s        = smp_s[11:0];
	assign p2_s        = smp_s[23:12];
	assign chan_sel    = p2_s[11];

	// ==========================================================
	// serial control port
	logic [4:0] bit_cnt_r;
	logic [7:0] sh_r;
	logic [7:0] instr_r;
	logic       out_r;
	logic [7:0] wr_data;
	logic [6:0] rd_addr;
	logic [7:0] rd_byte;
	logic       wr_now;
	logic       rd_phase;

	assign wr_data  = {sh_r[6:0], sdi_s};
	assign rd_addr  = instr_r[6:0];
	assign rd_byte  = (rd_addr < 7'(dicp_pkg::NREG)) ? regs_r[rd_addr[1:0]] : 8'h00;
	assign wr_now   = sclk_rise & ~sel_s & ~instr_r[7] & (bit_cnt_r == dicp_pkg::SER_BITS - 5'h01);
	assign rd_phase = ~sel_s & instr_r[7] & (bit_cnt_r >= dicp_pkg::SER_INSTR)
		& (bit_cnt_r < dicp_pkg::SER_BITS);

	// bit counter and shift register
	always_ff @(posedge aclk) begin
		sclk_d_r <= sclk_s;
		if (!aresetn || sel_s) begin
			bit_cnt_r <= 5'h00;
			sh_r      <= 8'h00;
		end else if (sclk_rise && bit_cnt_r < dicp_pkg::SER_BITS) begin
			sh_r      <= wr_data;
			bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end

	// instruction byte kept for the data phase
	always_ff @(posedge aclk) begin
		if (!aresetn || sel_s) begin
			instr_r <= 8'h00;
		end else if (sclk_rise && bit_cnt_r == dicp_pkg::SER_INSTR - 5'h01) begin
			instr_r <= wr_data;
		end
	end

	// read data launched on falling edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_r <= 1'b0;
		end else if (sclk_fall && rd_phase) begin
			out_r <= rd_byte[3'(~bit_cnt_r[2:0])];
		end
	end

	// ==========================================================
	// control registers, hardware and software reset
	always_ff @(posedge aclk) begin
		for (int i = 0; i < dicp_pkg::NREG; i++) begin
			if (!aresetn || hw_rst) begin
				regs_r[i] <= dicp_pkg::REG_RST[i];
			end else if (wr_now && rd_addr == dicp_pkg::A_CFG && wr_data[dicp_pkg::CFG_SRST_BIT]) begin
				if (i == 0) begin
					regs_r[i] <= wr_data;
				end else begin
					regs_r[i] <= dicp_pkg::REG_RST[i];
				end
			end else if (wr_now && rd_addr == 7'(i)) begin
				regs_r[i] <= wr_data;
			end
		end
	end

	// ==========================================================
	// interleave and rate clock dividers
	logic [3:0] ilv_cnt_r;
	logic       ilv_clk_r;
	logic       rate_clk_r;
	logic       ilv_fall;
	logic       rate_fall;
	logic       rate_rise_in;

	assign ilv_fall     = ilv_cnt_r == dicp_pkg::SMP_LAST;
	assign rate_fall    = ilv_fall & rate_clk_r;
	assign rate_rise_in = rate_s & ~rate_d_r;

	always_ff @(posedge aclk) begin
		rate_d_r <= rate_s;
		if (!aresetn) begin
			ilv_cnt_r  <= 4'h0;
			ilv_clk_r  <= 1'b0;
			rate_clk_r <= 1'b0;
		end else begin
			ilv_cnt_r  <= ilv_cnt_r + 4'h1;
			ilv_clk_r  <= (ilv_cnt_r + 4'h1) >= dicp_pkg::SMP_HALF;
			rate_clk_r <= rate_clk_r ^ ilv_fall;
		end
	end

	// ==========================================================
	// pin drivers
	assign lnk.rate_dev_o    = pll_en ? pll_locked : rate_clk_r;
	assign lnk.rate_dev_oe   = pll_en | rate_is_out;
	assign lnk.ilv_dev_o     = ilv_clk_r;
	assign lnk.ilv_dev_oe    = one_port & ~pll_en;
	assign lnk.sio_dev_o     = out_r;
	assign lnk.sio_dev_oe    = sio_out_cfg & rd_phase;
	assign lnk.serial_out_o  = (out_ck_cfg & ~one_port) ? rate_clk_r : out_r;
	assign lnk.serial_out_oe = ~sio_out_cfg;

	// ==========================================================
	// sample capture
	logic cap_one;
	logic cap_two;

	assign cap_one = one_port & ilv_fall;
	assign cap_two = ~one_port & (rate_is_out ? rate_fall : rate_rise_in);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			i_sample     <= 12'h000;
			q_sample     <= 12'h000;
			sample_valid <= 1'b0;
		end else begin
			sample_valid <= cap_one | cap_two;
			if (cap_one && chan_sel) begin
				i_sample <= p1_s;
			end else if (cap_one) begin
				q_sample <= p1_s;
			end else if (cap_two) begin
				i_sample <= p1_s;
				q_sample <= p2_s;
			end
		end
	end
endmodule

// *** design/dicp_host.sv ***
`timescale 1ns/100ps
// ==========================================================
// controller: bus registers, serial master, sample source
module dicp_host (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             irq,
	dicp_if.host             lnk
);
	// byte lane merge and address map
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				old[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return old;
	endfunction
	function automatic logic mapped(input logic [7:0] a);
		return a == dicp_pkg::H_CMD || a == dicp_pkg::H_STAT || a == dicp_pkg::H_IRQ
			|| a == dicp_pkg::H_MASK || a == dicp_pkg::H_MODE || a == dicp_pkg::H_SMP;
	endfunction

	// ==========================================================
	// bus slave
	logic                aw_r, w_r;
	logic [7:0]          wa_r;
	logic [31:0]         wd_r;
	logic [3:0]          ws_r;
	logic [15:0]         cmd_r;
	logic [7:0]          rx_r;
	logic [1:0]          irq_st_r, irq_mask_r;
	logic [3:0]          mode_r;
	logic [31:0]         smp_r;
	logic                do_wr, start, done_ev;
	logic [31:0]         rd_mux;
	logic [3:0]          pin_s;
	dicp_pkg::dicp_ser_e st_r;

	assign awready = ~aw_r & ~bvalid;
	assign wready  = ~w_r & ~bvalid;
	assign arready = ~rvalid;
	assign do_wr   = aw_r & w_r & ~bvalid;
	assign start   = do_wr & (wa_r == dicp_pkg::H_CMD) & (st_r == dicp_pkg::DICP_IDLE);
	assign irq     = |(irq_st_r & irq_mask_r);
	assign rd_mux  = (araddr == dicp_pkg::H_CMD)  ? {16'h0000, cmd_r} :
		(araddr == dicp_pkg::H_STAT) ? {22'h000000, pin_s[0], rx_r,
			st_r != dicp_pkg::DICP_IDLE} :
		(araddr == dicp_pkg::H_IRQ)  ? {30'h00000000, irq_st_r} :
		(araddr == dicp_pkg::H_MASK) ? {30'h00000000, irq_mask_r} :
		(araddr == dicp_pkg::H_MODE) ? {28'h0000000, mode_r} :
		(araddr == dicp_pkg::H_SMP)  ? smp_r : 32'h00000000;

	// write channels held until both arrive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_r <= 1'b0; w_r <= 1'b0; bvalid <= 1'b0; bresp <= dicp_pkg::RESP_OKAY;
			wa_r <= 8'h00; wd_r <= 32'h00000000; ws_r <= 4'h0;
		end else begin
			if (awvalid && awready) begin aw_r <= 1'b1; wa_r <= awaddr; end
			if (wvalid && wready) begin w_r <= 1'b1; wd_r <= wdata; ws_r <= wstrb; end
			if (do_wr) begin
				aw_r <= 1'b0; w_r <= 1'b0; bvalid <= 1'b1;
				bresp <= mapped(wa_r) ? dicp_pkg::RESP_OKAY : dicp_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0; rdata <= 32'h00000000; rresp <= dicp_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1; rdata <= rd_mux;
			rresp <= mapped(araddr) ? dicp_pkg::RESP_OKAY : dicp_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// registers; set of a status bit wins over its clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_r <= 16'h0000; irq_mask_r <= 2'h0; mode_r <= 4'h0; smp_r <= 32'h00000000; irq_st_r <= 2'h0;
		end else begin
			if (start) cmd_r <= 16'(merge({16'h0000, cmd_r}, wd_r, ws_r));
			if (do_wr && wa_r == dicp_pkg::H_MASK) irq_mask_r <= 2'(merge({30'h0, irq_mask_r}, wd_r, ws_r));
			if (do_wr && wa_r == dicp_pkg::H_MODE) mode_r <= 4'(merge({28'h0, mode_r}, wd_r, ws_r));
			if (do_wr && wa_r == dicp_pkg::H_SMP) smp_r <= merge(smp_r, wd_r, ws_r);
			irq_st_r <= (irq_st_r & ~((do_wr && wa_r == dicp_pkg::H_IRQ && ws_r[0]) ? wd_r[1:0] : 2'h0))
				| {1'b0, done_ev};
		end
	end

	// ==========================================================
	// serial master
	logic [3:0] div_r;
	logic [4:0] cnt_r;
	logic [15:0] tx_r;
	logic       sclk_r, cs_r, tick, din;

	dicp_sync #(.W(4)) u_hsync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({lnk.serial_out_pin, lnk.serial_io, lnk.second_port[10], lnk.rate_clock_or_lock_pin}),
		.q       (pin_s)
	);

	assign tick   = div_r == dicp_pkg::SCLK_LAST;
	assign din    = mode_r[2] ? pin_s[2] : pin_s[3];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= dicp_pkg::DICP_IDLE; div_r <= 4'h0; cnt_r <= 5'h00; tx_r <= 16'h0000;
			sclk_r <= 1'b0; cs_r <= 1'b1; rx_r <= 8'h00; done_ev <= 1'b0;
		end else begin
			div_r   <= (tick || start) ? 4'h0 : div_r + 4'h1;
			done_ev <= 1'b0;
			case (st_r)
				dicp_pkg::DICP_IDLE: begin
					if (start) begin
						st_r <= dicp_pkg::DICP_SHIFT; cs_r <= 1'b0; cnt_r <= 5'h00;
						tx_r <= 16'(merge({16'h0000, cmd_r}, wd_r, ws_r));
					end
				end
				dicp_pkg::DICP_SHIFT: begin
					if (tick) begin
						sclk_r <= ~sclk_r;
						if (!sclk_r) begin
							cnt_r <= cnt_r + 5'h01;
							if (cnt_r >= dicp_pkg::SER_INSTR) rx_r <= {rx_r[6:0], din};
						end else if (cnt_r == dicp_pkg::SER_BITS) begin
							st_r <= dicp_pkg::DICP_GAP; cs_r <= 1'b1;
						end else begin
							tx_r <= {tx_r[14:0], 1'b0};
						end
					end
				end
				dicp_pkg::DICP_GAP: begin
					if (tick) begin st_r <= dicp_pkg::DICP_IDLE; done_ev <= 1'b1; end
				end
				default: st_r <= dicp_pkg::DICP_IDLE;
			endcase
		end
	end

	logic rd_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) rd_r <= 1'b0;
		else if (start) rd_r <= wd_r[15];
	end

	assign lnk.serial_clk        = sclk_r;
	assign lnk.serial_select_pin = cs_r;
	assign lnk.sio_host_o        = tx_r[15];
	assign lnk.sio_host_oe       = (st_r == dicp_pkg::DICP_SHIFT) & ~(rd_r & mode_r[2] & cnt_r >= dicp_pkg::SER_INSTR);
	assign lnk.hw_reset          = mode_r[3];

	// ==========================================================
	// sample source
	logic [1:0]  edge_d_r;
	logic [3:0]  hdiv_r;
	logic        hrate_r, sel_r, upd;
	logic [11:0] p1_r, p2_r;

	assign upd = mode_r[0] ? (pin_s[1] & ~edge_d_r[1]) :
		mode_r[1] ? ((hdiv_r == dicp_pkg::SMP_LAST) & hrate_r) : (pin_s[0] & ~edge_d_r[0]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			edge_d_r <= 2'h0; hdiv_r <= 4'h0; hrate_r <= 1'b0; sel_r <= 1'b0; p1_r <= 12'h000; p2_r <= 12'h000;
		end else begin
			edge_d_r <= pin_s[1:0];
			hdiv_r   <= hdiv_r + 4'h1;
			hrate_r  <= hrate_r ^ (hdiv_r == dicp_pkg::SMP_LAST);
			if (upd && mode_r[0]) begin
				sel_r <= ~sel_r;
				p1_r  <= sel_r ? smp_r[27:16] : smp_r[11:0];
				p2_r  <= {~sel_r, 11'h000};
			end else if (upd) begin
				p1_r <= smp_r[11:0];
				p2_r <= smp_r[27:16];
			end
		end
	end

	assign lnk.first_port       = p1_r;
	assign lnk.second_port_h    = p2_r;
	assign lnk.second_port_h_oe = ~mode_r[0];
	assign lnk.rate_host_o      = hrate_r;
	assign lnk.rate_host_oe     = mode_r[1] & ~mode_r[0];
endmodule

// *** testbench/dicp_link_sva.sv ***
`timescale 1ns/100ps
// ==========================================================
// pin checker beside the link
module dicp_link_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pll_locked,
	input wire logic pll_en,
	input wire logic one_port,
	input wire logic rate_dev_o,
	input wire logic rate_dev_oe,
	input wire logic ilv_dev_o,
	input wire logic ilv_dev_oe,
	input wire logic serial_clk,
	input wire logic serial_select_pin,
	input wire logic serial_io,
	input wire logic sio_host_oe,
	input wire logic sio_dev_o,
	input wire logic sio_dev_oe,
	input wire logic serial_out_o,
	input wire logic serial_out_oe
);
	logic [4:0] rise_cnt_r;
	logic       sclk_q_r;
	// serial clock rises inside one frame
	always_ff @(posedge aclk) begin
		sclk_q_r <= serial_clk;
		if (!aresetn || serial_select_pin) begin
			rise_cnt_r <= 5'h00;
		end else if (serial_clk && !sclk_q_r) begin
			rise_cnt_r <= rise_cnt_r + 5'h01;
		end
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence lock_held; (pll_en && pll_locked)[*4]; endsequence
	sequence unlock_held; (pll_en && !pll_locked)[*4]; endsequence
	sequence ilv_wanted; (!pll_en && one_port)[*3]; endsequence
	lock_high_a: assert property (lock_held |-> rate_dev_oe && rate_dev_o)
		else $error("lock level not shown");
	lock_low_a: assert property (unlock_held |-> !rate_dev_o)
		else $error("unlocked pll shown high");
	ilv_drive_a: assert property (ilv_wanted |-> ilv_dev_oe)
		else $error("interleave clock not driven");
	ilv_idle_a: assert property ((pll_en || !one_port)[*3] |-> !ilv_dev_oe)
		else $error("interleave pin driven outside mode");
	ilv_period_a: assert property ($fell(ilv_dev_o) && ilv_dev_oe
		|-> $past(ilv_dev_o, 8) && !$past(ilv_dev_o, 9))
		else $error("interleave high phase not eight cycles");
	sdo_hiz_a: assert property (sio_dev_oe |-> !serial_out_oe)
		else $error("both serial outputs driven");
	sel_idle_a: assert property (serial_select_pin[*4] |-> !sio_dev_oe)
		else $error("data line driven while deselected");
	sclk_idle_a: assert property (serial_select_pin && $past(serial_select_pin) |-> !serial_clk)
		else $error("serial clock runs outside frame");
	sel_frame_a: assert property ($rose(serial_select_pin) |-> rise_cnt_r == 5'h10)
		else $error("frame not sixteen clocks");
	sdi_hold_a: assert property ($rose(serial_clk) && sio_host_oe |=> (!sio_host_oe || $stable(serial_io))[*3])
		else $error("input bit moved near rising edge");
	sio_launch_a: assert property (sio_dev_oe && $past(sio_dev_oe) && !serial_select_pin && $changed(sio_dev_o)
		|-> !serial_clk)
		else $error("data line bit launched while clock high");
	sdo_launch_a: assert property (serial_out_oe && $past(serial_out_oe) && !serial_select_pin
		&& $changed(serial_out_o) && $changed(sio_dev_o) |-> !serial_clk)
		else $error("out pin bit launched while clock high");
endmodule

// *** testbench/dac_input_and_control_port_tb.sv ***
`timescale 1ns/100ps
// ==========================================================
// bench: bus master on the controller, converter on the far side
module dac_input_and_control_port_tb;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic        rvalid, rready, irq, pll_locked, sample_valid, one_port, pll_en, msk, prev;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, r;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [11:0] i_sample, q_sample;
	int          failures, tests_run, edges;
	dicp_if u_lnk ();
	dicp_dev u_dicp_dev (.aclk(aclk), .aresetn(aresetn), .lnk(u_lnk.dev), .pll_locked(pll_locked),
		.i_sample(i_sample), .q_sample(q_sample), .sample_valid(sample_valid), .one_port(one_port), .pll_en(pll_en));
	dicp_host u_dicp_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .irq(irq), .lnk(u_lnk.host));
	dicp_link_sva u_dicp_link_sva (.aclk(aclk), .aresetn(aresetn), .pll_locked(pll_locked), .pll_en(pll_en),
		.one_port(one_port), .rate_dev_o(u_lnk.rate_dev_o), .rate_dev_oe(u_lnk.rate_dev_oe),
		.ilv_dev_o(u_lnk.ilv_dev_o), .ilv_dev_oe(u_lnk.ilv_dev_oe), .serial_clk(u_lnk.serial_clk),
		.serial_select_pin(u_lnk.serial_select_pin), .serial_io(u_lnk.serial_io), .sio_host_oe(u_lnk.sio_host_oe),
		.sio_dev_o(u_lnk.sio_dev_o), .sio_dev_oe(u_lnk.sio_dev_oe), .serial_out_o(u_lnk.serial_out_o),
		.serial_out_oe(u_lnk.serial_out_oe));
	// 200 MHz clock
	always #2.5 aclk = ~aclk;
	// ==========================================================
	// compare, bus and link tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = dicp_pkg::RESP_OKAY);
		logic       ah, wh, bh;
		logic [1:0] rs;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		bh = 1'h0;
		while (!bh) begin
			@(negedge aclk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = (bvalid === 1'h1);
			rs = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'h0;
			if (wh) wvalid <= 1'h0;
		end
		// bready stays high, so back to back calls never touch it twice in one step
		chk({30'h0, rs}, {30'h0, er});
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = dicp_pkg::RESP_OKAY);
		logic       ah, rh;
		logic [1:0] rs;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		rh = 1'h0;
		while (!rh) begin
			@(negedge aclk);
			ah = arvalid & arready;
			rh = (rvalid === 1'h1);
			d = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'h0;
		end
		// rready stays high for the same reason
		chk({30'h0, rs}, {30'h0, er});
	endtask
	// poll the done flag, check the interrupt line, clear by writing one
	task wait_done();
		int n;
		n = 0;
		r = 32'h0;
		while (r[0] !== 1'h1 && n < 400) begin
			rd(dicp_pkg::H_IRQ, r);
			n++;
		end
		chk({31'h0, r[0]}, 32'h1);
		chk({31'h0, irq}, {31'h0, msk});
		wr(dicp_pkg::H_IRQ, 32'h1);
		chk({31'h0, irq}, 32'h0);
	endtask
	task dev_wr(input logic [6:0] a, input logic [7:0] v);
		wr(dicp_pkg::H_CMD, {16'h0, 1'h0, a, v});
		wait_done();
	endtask
	task dev_rd(input logic [6:0] a, input logic [7:0] e);
		wr(dicp_pkg::H_CMD, {16'h0, 1'h1, a, 8'h00});
		wait_done();
		rd(dicp_pkg::H_STAT, r);
		chk({24'h0, r[8:1]}, {24'h0, e});
	endtask
	// set both ends up, stream one sample pair, check capture
	task smp(input logic [7:0] m1, input logic [7:0] c2, input logic [31:0] hm, input logic [11:0] i,
		input logic [11:0] q);
		int n;
		dev_wr(dicp_pkg::A_CLK, c2);
		dev_wr(dicp_pkg::A_MODE, m1);
		wr(dicp_pkg::H_MODE, hm);
		wr(dicp_pkg::H_SMP, {4'h0, q, 4'h0, i});
		n = 0;
		repeat (300) begin
			@(negedge aclk);
			if (sample_valid === 1'h1)
				n++;
		end
		@(posedge aclk);
		chk({20'h0, i_sample}, {20'h0, i});
		chk({20'h0, q_sample}, {20'h0, q});
		chk({31'h0, n > 3}, 32'h1);
	endtask
	task test_done();
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// test sequence
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pll_locked, msk} = 9'h000;
		{awaddr, araddr, wdata, r} = 80'h0;
		wstrb = 4'hF;
		failures = 0;
		tests_run = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		wr(8'h40, 32'h5, dicp_pkg::RESP_SLVERR);
		rd(8'h40, r, dicp_pkg::RESP_SLVERR);
		chk(r, 32'h0);
		dev_rd(dicp_pkg::A_CFG, 8'h00);
		dev_rd(dicp_pkg::A_CLK, 8'h00);
		msk = 1'h1;
		wr(dicp_pkg::H_MASK, 32'h1);
		dev_wr(dicp_pkg::A_MODE, 8'h02);
		pll_locked <= 1'h1;
		repeat (12) @(posedge aclk);
		rd(dicp_pkg::H_STAT, r);
		chk({31'h0, r[9]}, 32'h1);
		pll_locked <= 1'h0;
		repeat (12) @(posedge aclk);
		rd(dicp_pkg::H_STAT, r);
		chk({31'h0, r[9]}, 32'h0);
		msk = 1'h0;
		wr(dicp_pkg::H_MASK, 32'h0);
		dev_wr(dicp_pkg::A_MODE, 8'h00);
		dev_wr(dicp_pkg::A_CFG, 8'h80);
		wr(dicp_pkg::H_MODE, 32'h4);
		dev_wr(dicp_pkg::A_CLK, 8'h08);
		dev_rd(dicp_pkg::A_CLK, 8'h08);
		dev_rd(dicp_pkg::A_CFG, 8'h80);
		dev_wr(dicp_pkg::A_CFG, 8'h00);
		wr(dicp_pkg::H_MODE, 32'h0);
		dev_rd(dicp_pkg::A_CLK, 8'h08);
		smp(8'h01, 8'h00, 32'h1, 12'h3C1, 12'hA5C);
		chk({31'h0, u_lnk.ilv_dev_oe}, 32'h1);
		smp(8'h00, 8'h08, 32'h0, 12'h5A3, 12'h8E7);
		chk({31'h0, u_lnk.rate_dev_oe}, 32'h1);
		smp(8'h00, 8'h00, 32'h2, 12'h0F1, 12'hC3E);
		chk({31'h0, u_lnk.rate_dev_oe}, 32'h0);
		// rate clock on the out pin: one toggle every 16 cycles
		dev_wr(dicp_pkg::A_MODE, 8'h04);
		edges = 0;
		@(negedge aclk);
		prev = u_lnk.serial_out_pin;
		repeat (64) begin
			@(negedge aclk);
			if (u_lnk.serial_out_pin !== prev)
				edges++;
			prev = u_lnk.serial_out_pin;
		end
		chk(edges, 32'h4);
		dev_wr(dicp_pkg::A_MODE, 8'h01);
		dev_wr(dicp_pkg::A_CLK, 8'h08);
		dev_wr(dicp_pkg::A_CFG, 8'h20);
		dev_rd(dicp_pkg::A_MODE, 8'h00);
		dev_rd(dicp_pkg::A_CLK, 8'h00);
		dev_rd(dicp_pkg::A_CFG, 8'h20);
		dev_wr(dicp_pkg::A_CFG, 8'h80);
		dev_wr(dicp_pkg::A_MODE, 8'h01);
		wr(dicp_pkg::H_MODE, 32'h8);
		repeat (10) @(posedge aclk);
		wr(dicp_pkg::H_MODE, 32'h0);
		repeat (10) @(posedge aclk);
		dev_rd(dicp_pkg::A_CFG, 8'h00);
		dev_rd(dicp_pkg::A_MODE, 8'h00);
		test_done();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (50000) @(posedge aclk);
		failures++;
		test_done();
	end
endmodule
